// *** inc/serial_rx_pkg.sv ***
// ==========================================================================
// Shared constants and types of the serial receive error flag block.
package serial_rx_pkg;

  // ==========================================================================
  // Register byte offsets on the APB.
  localparam logic [4:0] ADDR_DATA   = 5'h00;
  localparam int         IDX_STATUS  = 3;     // Status sits at word index three.
  localparam logic [4:0] ADDR_STATUS = 5'(4 * IDX_STATUS);
  localparam logic [4:0] ADDR_BAUD   = 5'h08;
  localparam logic [4:0] ADDR_LEVEL  = 5'h04;
  localparam logic [4:0] ADDR_INT_ST = 5'h10;
  localparam logic [4:0] ADDR_INT_CL = 5'h14;
  localparam logic [4:0] ADDR_INT_EN = 5'h18;

  // ==========================================================================
  // Status register field positions.
  localparam int STAT_WM_FULL = 13;
  localparam int STAT_OR      = 11;
  localparam int STAT_NOISE   = 10;
  localparam int STAT_STOP    = 9;

  // Interrupt status field positions.
  localparam int INT_RX    = 0;
  localparam int INT_OR    = 1;
  localparam int INT_NOISE = 2;
  localparam int INT_STOP  = 3;
  localparam int INT_W     = 4;

  // Level register field positions.
  localparam int LVL_WM_LSB  = 0;
  localparam int LVL_CNT_LSB = 8;

  // ==========================================================================
  // Sizes, reset values and oversampling points.
  localparam int FIFO_DEPTH = 4;
  localparam int FIFO_AW    = 2;
  localparam int FIFO_CW    = 3;
  localparam logic [15:0] BAUD_RESET = 16'h0015;
  localparam logic [2:0]  WM_RESET   = 3'h0;
  localparam logic [3:0]  PHASE_A    = 4'h7;
  localparam logic [3:0]  PHASE_B    = 4'h8;
  localparam logic [3:0]  PHASE_C    = 4'h9;
  localparam logic [3:0]  PHASE_END  = 4'hf;
  localparam logic [2:0]  LAST_BIT   = 3'h7;

  // One received frame as it leaves the shift register.
  typedef struct packed {
    logic [7:0] data;
    logic       noise;
    logic       stop_bad;
  } rx_frame_t;

endpackage : serial_rx_pkg

// *** rtl/rx_fifo.sv ***
`timescale 1ns/100ps
`default_nettype none
// ==========================================================================
// Receive word store; a push while full is never issued by the owner.
module rx_fifo
  import serial_rx_pkg::*;
(
  // Clock and reset.
  input  wire logic               pclk,
  input  wire logic               presetn,
  // Write and read strobes.
  input  wire logic               push,
  input  wire logic [7:0]         wdata,
  input  wire logic               pop,
  // State.
  output logic      [7:0]         head,
  output logic      [FIFO_CW-1:0] count
);

  logic [7:0]         mem [FIFO_DEPTH];
  logic [FIFO_AW-1:0] wptr;
  logic [FIFO_AW-1:0] rptr;
  logic               do_push;
  logic               do_pop;

  assign do_push = push && (count != FIFO_CW'(FIFO_DEPTH));
  assign do_pop  = pop && (count != '0);
  assign head    = mem[rptr];

  // Storage array.
  always_ff @(posedge pclk) begin
    if (do_push) begin
      mem[wptr] <= wdata;
    end
  end

  // Pointers and word count.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wptr  <= '0;
      rptr  <= '0;
      count <= '0;
    end else begin
      if (do_push) begin
        wptr <= wptr + 1'b1;
      end
      if (do_pop) begin
        rptr <= rptr + 1'b1;
      end
      count <= count + FIFO_CW'(do_push) - FIFO_CW'(do_pop);
    end
  end

endmodule : rx_fifo
`default_nettype wire

// *** rtl/rx_frame.sv ***
`timescale 1ns/100ps
`default_nettype none
// ==========================================================================
// Receive shift register: 8N1 frames, 16x oversampling, majority vote.
module rx_frame
  import serial_rx_pkg::*;
(
  // Clock and reset.
  input  wire logic      pclk,
  input  wire logic      presetn,
  // Oversampling enable and synchronised line.
  input  wire logic      tick,
  input  wire logic      rxd,
  // Completed frame.
  output logic           done,
  output rx_frame_t      frame
);

  typedef enum logic [1:0] {
    RX_IDLE  = 2'b00,
    RX_START = 2'b01,
    RX_DATA  = 2'b10,
    RX_STOP  = 2'b11
  } rx_state_t;

  rx_state_t  state;
  logic [3:0] phase;
  logic [2:0] samples;
  logic [2:0] bitcnt;
  logic [7:0] shift;
  logic       noise_acc;
  logic       vote;
  logic       noisy;

  // Majority of three samples; any disagreement counts as noise.
  assign vote  = (samples[0] & samples[1]) | (samples[1] & samples[2]) |
                 (samples[0] & samples[2]);
  assign noisy = (samples != 3'h0) && (samples != 3'h7);

  // Bit timing and frame assembly.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state     <= RX_IDLE;
      phase     <= 4'h0;
      samples   <= 3'h7;
      bitcnt    <= 3'h0;
      shift     <= 8'h00;
      noise_acc <= 1'b0;
      done      <= 1'b0;
      frame     <= '0;
    end else begin
      done <= 1'b0;
      if (tick) begin
        phase <= phase + 4'h1;
        if (phase == PHASE_A || phase == PHASE_B || phase == PHASE_C) begin
          samples <= {samples[1:0], rxd};
        end
        unique case (state)
          RX_IDLE: begin
            phase <= 4'h0;
            if (!rxd) begin
              state <= RX_START;
            end
          end
          RX_START: begin
            if (phase == PHASE_END) begin
              state     <= vote ? RX_IDLE : RX_DATA;
              noise_acc <= noisy;
              bitcnt    <= 3'h0;
            end
          end
          RX_DATA: begin
            if (phase == PHASE_END) begin
              shift     <= {vote, shift[7:1]};
              noise_acc <= noise_acc | noisy;
              bitcnt    <= bitcnt + 3'h1;
              if (bitcnt == LAST_BIT) begin
                state <= RX_STOP;
              end
            end
          end
          RX_STOP: begin
            if (phase == PHASE_END) begin
              done  <= 1'b1;
              frame <= '{data: shift, noise: noise_acc | noisy, stop_bad: ~vote};
              state <= RX_IDLE;
            end
          end
        endcase
      end
    end
  end

endmodule : rx_frame
`default_nettype wire

// *** rtl/serial_rx_error_flags.sv ***
// Local design decisions: the APB slave port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
// ==========================================================================
// Serial receiver with overrun, noise and framing flags behind an APB slave.

// Behaviour
// - A frame completing while the receive store is full sets the overrun flag, bit 11.
// - On overrun the new frame is dropped and stored words stay untouched.
// - Overrun clears when a status read saw it set and a status write follows.
// - While overrun is set, arriving frames are ignored and set no other flag.
// - Noise sets bit 10 at the edge that stores the word, never on an overrun frame.
// - Noise clears when a status read saw it set and a status write follows.
// - A zero stop bit sets bit 9 at the edge that stores the word, never on overrun.
// - Framing error clears when a status read saw it set and a status write follows.
// - Data-full, bit 13, is high while the stored word count exceeds the watermark.
module serial_rx_error_flags
  import serial_rx_pkg::*;
(
  // Clock and reset.
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [4:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Serial receive pin.
  input  wire logic        rxd_pin,
  // Interrupt.
  output logic             irq
);

  // ==========================================================================
  // Address decoding.

  // True when the address selects the given register.
  function automatic logic hit(input logic [4:0] addr, input logic [4:0] offs);
    hit = (addr == offs);
  endfunction : hit

  // True when the address selects any mapped register.
  function automatic logic mapped(input logic [4:0] addr);
    mapped = hit(addr, ADDR_DATA) || hit(addr, ADDR_STATUS) ||
             hit(addr, ADDR_BAUD) || hit(addr, ADDR_LEVEL) ||
             hit(addr, ADDR_INT_ST) || hit(addr, ADDR_INT_CL) ||
             hit(addr, ADDR_INT_EN);
  endfunction : mapped

  // ==========================================================================
  // Declarations.

  logic               rxd_meta;
  logic               rxd_sync;
  logic [15:0]        baud_div;
  logic [15:0]        baud_cnt;
  logic               tick;
  logic               frame_done;
  rx_frame_t          frame;
  logic               push;
  logic               pop;
  logic [7:0]         fifo_head;
  logic [FIFO_CW-1:0] fifo_count;
  logic [FIFO_CW-1:0] watermark;
  logic               fifo_full;
  logic               rx_watermark_full_flag;
  logic               wm_full_q;
  logic               flag_or;
  logic               line_noise_flag;
  logic               bad_stop_bit_flag;
  logic               arm_or;
  logic               arm_noise;
  logic               arm_stop;
  logic               set_or;
  logic               set_noise;
  logic               set_stop;
  logic               accepted;
  logic               overrun;
  logic               access;
  logic               done_xfer;
  logic               wr_done;
  logic               rd_done;
  logic               stat_wr;
  logic [15:0]        status;
  logic [INT_W-1:0]   int_status;
  logic [INT_W-1:0]   int_enable;
  logic [INT_W-1:0]   int_events;
  logic [INT_W-1:0]   int_clear;
  logic [31:0]        next_rdata;

  // ==========================================================================
  // Line synchroniser and baud enable.

  // Two flip-flops bring the pin into the clock domain; idle line is high.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rxd_meta <= 1'b1;
      rxd_sync <= 1'b1;
    end else begin
      rxd_meta <= rxd_pin;
      rxd_sync <= rxd_meta;
    end
  end

  // Divider gives one enable pulse per oversampling slot.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      baud_cnt <= 16'h0000;
      tick     <= 1'b0;
    end else if (baud_cnt >= baud_div) begin
      baud_cnt <= 16'h0000;
      tick     <= 1'b1;
    end else begin
      baud_cnt <= baud_cnt + 16'h0001;
      tick     <= 1'b0;
    end
  end

  // ==========================================================================
  // Receive path.

  rx_frame u_rx_frame (
    .pclk    (pclk),
    .presetn (presetn),
    .tick    (tick),
    .rxd     (rxd_sync),
    .done    (frame_done),
    .frame   (frame)
  );

  // A frame is stored only when there is room and no overrun is pending.
  assign fifo_full = (fifo_count == FIFO_CW'(FIFO_DEPTH));
  assign accepted  = frame_done && !flag_or && !fifo_full;
  assign overrun   = frame_done && !flag_or && fifo_full;
  assign push      = accepted;

  rx_fifo u_rx_fifo (
    .pclk    (pclk),
    .presetn (presetn),
    .push    (push),
    .wdata   (frame.data),
    .pop     (pop),
    .head    (fifo_head),
    .count   (fifo_count)
  );

  // Data-full follows the word count against the watermark.
  assign rx_watermark_full_flag = (fifo_count > watermark);

  // ==========================================================================
  // Error flag setting.

  // Noise and framing sets act at the edge that pushes the word, so those flags and
  // the word count change in the same cycle.
  assign set_or    = overrun;
  assign set_noise = accepted && frame.noise;
  assign set_stop  = accepted && frame.stop_bad;

  // ==========================================================================
  // APB transfer control.

  assign access    = psel && penable;
  assign done_xfer = access && pready;
  assign wr_done   = done_xfer && pwrite;
  assign rd_done   = done_xfer && !pwrite;
  assign stat_wr   = wr_done && hit(paddr, ADDR_STATUS) && !pslverr;
  assign pop       = rd_done && hit(paddr, ADDR_DATA);

  // Ready rises one cycle into the access phase and falls after the edge.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= access && !pready;
      pslverr <= access && !pready && !mapped(paddr);
    end
  end

  // ==========================================================================
  // Status clearing sequence.

  // A status read arms each error flag it returned as set.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      arm_or    <= 1'b0;
      arm_noise <= 1'b0;
      arm_stop  <= 1'b0;
    end else if (rd_done && hit(paddr, ADDR_STATUS)) begin
      arm_or    <= prdata[STAT_OR];
      arm_noise <= prdata[STAT_NOISE];
      arm_stop  <= prdata[STAT_STOP];
    end else if (stat_wr) begin
      arm_or    <= 1'b0;
      arm_noise <= 1'b0;
      arm_stop  <= 1'b0;
    end
  end

  // Overrun flag; a new set in the clearing cycle wins.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_or <= 1'b0;
    end else begin
      flag_or <= (flag_or && !(stat_wr && arm_or)) || set_or;
    end
  end

  // Noise flag; a new set in the clearing cycle wins.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_noise_flag <= 1'b0;
    end else begin
      line_noise_flag <= (line_noise_flag && !(stat_wr && arm_noise))
                         || set_noise;
    end
  end

  // Framing flag; a new set in the clearing cycle wins.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bad_stop_bit_flag <= 1'b0;
    end else begin
      bad_stop_bit_flag <= (bad_stop_bit_flag && !(stat_wr && arm_stop))
                           || set_stop;
    end
  end

  // Status view; reserved bits read as zero.
  always_comb begin
    status               = 16'h0000;
    status[STAT_WM_FULL] = rx_watermark_full_flag;
    status[STAT_OR]      = flag_or;
    status[STAT_NOISE]   = line_noise_flag;
    status[STAT_STOP]    = bad_stop_bit_flag;
  end

  // ==========================================================================
  // Control registers.

  // Baud divisor and watermark are written by software.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      baud_div  <= BAUD_RESET;
      watermark <= WM_RESET;
    end else if (wr_done && !pslverr) begin
      if (hit(paddr, ADDR_BAUD)) begin
        baud_div <= pwdata[15:0];
      end
      if (hit(paddr, ADDR_LEVEL)) begin
        watermark <= pwdata[LVL_WM_LSB +: FIFO_CW];
      end
    end
  end

  // ==========================================================================
  // Interrupts.

  // Data-full rising edge and each error set are interrupt events.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wm_full_q <= 1'b0;
    end else begin
      wm_full_q <= rx_watermark_full_flag;
    end
  end

  // Event vector, and the mask of a write to the clear register.
  always_comb begin
    int_events            = '0;
    int_events[INT_RX]    = rx_watermark_full_flag && !wm_full_q;
    int_events[INT_OR]    = set_or;
    int_events[INT_NOISE] = set_noise;
    int_events[INT_STOP]  = set_stop;
    int_clear          = '0;
    if (wr_done && !pslverr && hit(paddr, ADDR_INT_CL)) begin
      int_clear = pwdata[INT_W-1:0];
    end
  end

  // Sticky bits, write-one-to-clear through the clear register; set wins.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_status <= '0;
    end else begin
      int_status <= (int_status & ~int_clear) | int_events;
    end
  end

  // Enable register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_enable <= '0;
    end else if (wr_done && !pslverr && hit(paddr, ADDR_INT_EN)) begin
      int_enable <= pwdata[INT_W-1:0];
    end
  end

  // Level interrupt output.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(((int_status & ~int_clear) | int_events) & int_enable);
    end
  end

  // ==========================================================================
  // Read data.

  // Read mux; write-only and unmapped addresses return zero.
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (hit(paddr, ADDR_DATA)) begin
      next_rdata[7:0] = fifo_head;
    end
    if (hit(paddr, ADDR_STATUS)) begin
      next_rdata[15:0] = status;
    end
    if (hit(paddr, ADDR_BAUD)) begin
      next_rdata[15:0] = baud_div;
    end
    if (hit(paddr, ADDR_LEVEL)) begin
      next_rdata[LVL_WM_LSB +: FIFO_CW]  = watermark;
      next_rdata[LVL_CNT_LSB +: FIFO_CW] = fifo_count;
    end
    if (hit(paddr, ADDR_INT_ST)) begin
      next_rdata[INT_W-1:0] = int_status;
    end
    if (hit(paddr, ADDR_INT_EN)) begin
      next_rdata[INT_W-1:0] = int_enable;
    end
  end

  // Read data is captured as ready rises and held until the next capture.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (access && !pready && !pwrite) begin
      prdata <= next_rdata;
    end
  end

endmodule : serial_rx_error_flags
`default_nettype wire

// *** tb/serial_rx_error_flags_test.sv ***
`timescale 1ns/100ps
`default_nettype none
// ==========================================================================
// Self-checking bench of the receive flag block.
module serial_rx_error_flags_test
  import serial_rx_pkg::*;
();

  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, rxd_pin, irq;
  logic [4:0]  paddr;
  logic [31:0] pwdata, prdata, seed;
  logic [32:0] exp_q[$];
  logic [7:0]  b[6];
  logic [32:0] flag;
  int          n_mismatch, num_checks;

  serial_rx_error_flags u_serial_rx_error_flags (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rxd_pin(rxd_pin), .irq(irq));
  serial_tx_model #(.BIT_CLKS(32)) u_serial_tx_model (.pclk(pclk), .line(rxd_pin));

  function automatic logic [31:0] xorshift(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xorshift

  task automatic chk(input string what, input logic [32:0] e, input logic [32:0] got);
    num_checks++;
    if (got !== e) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", what, e, got);
    end
  endtask : chk

  // One APB transfer; a read leaves its expected {pslverr, prdata} in the queue.
  task automatic apb(input logic w, input logic [4:0] a, input logic [31:0] d,
                     input logic [32:0] e);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    if (!w) exp_q.push_back(e);
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (!pready) @(posedge pclk);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 33'h0);
  endtask : wr

  task automatic rd(input logic [4:0] a, input logic [32:0] e);
    apb(1'b0, a, 32'h0, e);
  endtask : rd

  task automatic frame(input logic [7:0] d, input logic stop_ok, input logic noisy);
    u_serial_tx_model.send(d, stop_ok, noisy);
    repeat (8) @(posedge pclk);
  endtask : frame

  task automatic report_and_stop;
    repeat (2) @(posedge pclk);
    if (n_mismatch == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : report_and_stop

  // Clock generator.
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  // Every completed read is compared with the oldest expectation.
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite) chk("read", exp_q.pop_front(), {pslverr, prdata});
  end

  // Watchdog against a hung handshake.
  initial begin
    repeat (20000) @(posedge pclk);
    n_mismatch++;
    report_and_stop();
  end

  // Main sequence.
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    seed = 32'h0000_2d9e;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values and an unmapped place.
    rd(ADDR_STATUS, 33'h0);
    rd(ADDR_BAUD, {17'h0, BAUD_RESET});
    rd(ADDR_LEVEL, 33'h0);
    rd(ADDR_INT_EN, 33'h0);
    wr(5'h1c, 32'hffff_ffff);
    rd(5'h1c, 33'h1_0000_0000);
    wr(ADDR_BAUD, 32'h1);
    wr(ADDR_INT_EN, 32'hf);
    // A clean frame raises data-full only.
    seed = xorshift(seed);
    frame(seed[7:0], 1'b1, 1'b0);
    chk("irq", 33'h1, {32'h0, irq});
    rd(ADDR_STATUS, 33'h2000);
    rd(ADDR_DATA, {25'h0, seed[7:0]});
    rd(ADDR_STATUS, 33'h0);
    // Framing, then noise: an unarmed write keeps the flag, read then write clears it.
    for (int k = 0; k < 2; k++) begin
      seed = xorshift(seed);
      flag = (k == 0) ? 33'h200 : 33'h400;
      frame(seed[7:0], k == 1, k == 1);
      wr(ADDR_STATUS, seed);
      rd(ADDR_STATUS, 33'h2000 | flag);
      wr(ADDR_STATUS, 32'h0);
      rd(ADDR_STATUS, 33'h2000);
      rd(ADDR_DATA, {25'h0, seed[7:0]});
    end
    // Fill the store, overrun with a noisy bad-stop frame, then a noisy frame in overrun.
    for (int k = 0; k < 6; k++) begin
      seed = xorshift(seed);
      b[k] = seed[7:0];
      frame(b[k], k != 4, k >= 4);
    end
    rd(ADDR_LEVEL, 33'h400);
    rd(ADDR_STATUS, 33'h2800);
    wr(ADDR_STATUS, 32'h0);
    rd(ADDR_STATUS, 33'h2000);
    for (int k = 0; k < 4; k++) rd(ADDR_DATA, {25'h0, b[k]});
    rd(ADDR_STATUS, 33'h0);
    // Interrupt events, clearing and masking.
    rd(ADDR_INT_ST, 33'hf);
    chk("irq", 33'h1, {32'h0, irq});
    wr(ADDR_INT_CL, 32'hf);
    rd(ADDR_INT_ST, 33'h0);
    rd(ADDR_INT_CL, 33'h0);
    chk("irq", 33'h0, {32'h0, irq});
    wr(ADDR_INT_EN, 32'h0);
    seed = xorshift(seed);
    frame(seed[7:0], 1'b1, 1'b0);
    chk("irq", 33'h0, {32'h0, irq});
    rd(ADDR_INT_ST, 33'h1);
    wr(ADDR_INT_EN, 32'h1);
    repeat (3) @(posedge pclk);
    chk("irq", 33'h1, {32'h0, irq});
    report_and_stop();
  end
endmodule : serial_rx_error_flags_test
`default_nettype wire

// *** tb/serial_rx_flags_chk_sva.sv ***
`timescale 1ns/100ps
`default_nettype none
// ==========================================================================
// Checker on the pins of the receive flag block.
module serial_rx_flags_chk
  import serial_rx_pkg::*;
(
  // Clock and reset.
  input wire logic        pclk,
  input wire logic        presetn,
  // APB slave side.
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [4:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Serial pin and interrupt.
  input wire logic        rxd_pin,
  input wire logic        irq
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  logic       rd_st;
  logic       wr_st;
  logic       wr_any;
  logic [2:0] known;
  logic [2:0] armed;

  // Completed transfers seen on the bus.
  assign wr_any = psel && penable && pready && pwrite;
  assign wr_st  = wr_any && paddr == ADDR_STATUS;
  assign rd_st  = psel && penable && pready && !pwrite && paddr == ADDR_STATUS;

  // Error flags last seen set, and those that a status write may clear.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      known <= 3'h0;
      armed <= 3'h0;
    end else if (rd_st) begin
      known <= prdata[11:9];
      armed <= prdata[11:9];
    end else if (wr_st) begin
      known <= known & ~armed;
      armed <= 3'h0;
    end
  end

  sequence setup_then_access;
    psel && !penable ##1 psel && penable;
  endsequence

  pready_timing_a: assert property (setup_then_access |-> !pready ##1 pready)
    else $error("pready not in the second access cycle");
  pready_pulse_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  ready_in_access_a: assert property (pready |-> psel && penable)
    else $error("pready outside an access");
  unmapped_err_a: assert property (pready && paddr[1:0] == 2'h0 |-> pslverr == (paddr == 5'h1c))
    else $error("pslverr wrong for address");
  err_with_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  status_fields_a: assert property (rd_st |-> prdata[31:14] == 18'h0 && prdata[12] == 1'b0
                                    && prdata[8:0] == 9'h0)
    else $error("status holds bits outside its flags");
  flag_hold_a: assert property (rd_st |-> (known & ~prdata[11:9]) == 3'h0)
    else $error("error flag cleared without read then write");
  prdata_hold_a: assert property (!(psel && penable && !pwrite) |=> $stable(prdata))
    else $error("prdata changed outside a read");
  irq_drop_a: assert property ($fell(irq) |-> $past(wr_any) || $past(wr_any, 2) || $past(wr_any, 3))
    else $error("irq fell without a register write");
endmodule : serial_rx_flags_chk

bind serial_rx_error_flags serial_rx_flags_chk u_serial_rx_flags_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .rxd_pin(rxd_pin), .irq(irq));
`default_nettype wire

// *** tb/serial_tx_model.sv ***
`timescale 1ns/100ps
`default_nettype none
// ==========================================================================
// Remote transmitter: 8N1 frames, LSB first, line idles high.
module serial_tx_model #(
  parameter int BIT_CLKS = 32
) (
  // Clock.
  input  wire logic pclk,
  // Serial line towards the receiver.
  output var logic  line
);
  initial line = 1'b1;

  // Sends one frame; a two-clock glitch lands mid data bit 0, the stop bit may be 0.
  task automatic send(input logic [7:0] b, input logic stop_ok, input logic noisy);
    logic [9:0] bits;
    bits = {stop_ok, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      for (int c = 0; c < BIT_CLKS; c++) begin
        @(posedge pclk);
        line <= (noisy && i == 1 && (c == 17 || c == 18)) ? ~bits[i] : bits[i];
      end
    end
    @(posedge pclk);
    line <= 1'b1;
  endtask : send
endmodule : serial_tx_model
`default_nettype wire
